/* hw/dist_regs.svh */
`ifndef DIST_REGS_SVH
`define DIST_REGS_SVH

// byte offsets inside the distributor frame
`define CAPS_OFFSET 12'h004
`define ERR_STAT_OFFSET 12'h010
`define SET_SHARED_NS_OFFSET 12'h040
`define CLR_SHARED_NS_OFFSET 12'h048
`define SET_SHARED_S_OFFSET 12'h050
`define CLR_SHARED_S_OFFSET 12'h058
`define SOFT_GEN_OFFSET 12'hF00
`define SGI_PEND_BASE 12'hF20
`define SGI_PEND_SPAN_MASK 12'hFF0

// error status field positions
`define ERR_WO_READ_BIT 2
`define ERR_RSV_WRITE_BIT 1
`define ERR_RSV_READ_BIT 0

// capability field positions
`define CAP_ONE_OF_N_BIT 25
`define CAP_AFF3_BIT 24
`define CAP_IDW_MSB 23
`define CAP_IDW_LSB 19
`define CAP_DVI_BIT 18
`define CAP_LPI_BIT 17
`define CAP_MSG_BIT 16
`define CAP_SEC_BIT 10
`define CAP_TGT_MSB 7
`define CAP_TGT_LSB 5
`define CAP_SPI_MSB 4
`define CAP_SPI_LSB 0

// reset values and sizes
`define SGI_PEND_RESET 32'h0000_0000
`define ERR_STAT_RESET 3'h0
`define FIELD_BITS 8
`define SPI_PER_STEP 11'h020
`define SPI_FIRST_SPECIAL 11'h3FC
`define SPI_LAST_USABLE 10'h3FB

`endif

/* hw/dist_pkg.sv */
package dist_pkg;
    // pending bits: 16 soft interrupts x 8 processing elements
    typedef struct packed {
        logic [127:0] pend;
    } pend_state_t;
    // one bank of error flags
    typedef struct packed {
        logic [2:0] flags;
    } err_state_t;
    // register-port state of the top block
    typedef struct packed {
        logic [31:0] rdata;
        logic done;
        logic [9:0] spi_limit;
    } bank_state_t;
endpackage

/* hw/err_flags.sv */
`timescale 1ns/1ps
`include "dist_regs.svh"

// one bank of sticky access-error flags, cleared by writing one
module err_flags
    import dist_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [2:0] set_flags,
    input wire logic [2:0] clr_flags,
    output logic [2:0] flags
);
    err_state_t st_reg; // registered flags
    err_state_t st_next; // next value

    // a detection in the clearing cycle survives: set wins
    always_comb begin
        st_next = st_reg;
        st_next.flags = (st_reg.flags & ~clr_flags) | set_flags;
    end

    // flags may reset to anything; zero is the quiet choice
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '{flags: `ERR_STAT_RESET};
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign flags = st_reg.flags;
endmodule

/* hw/sgi_pend_bank.sv */
`timescale 1ns/1ps
`include "dist_regs.svh"

// pending state of each soft interrupt per requesting element
module sgi_pend_bank
    import dist_pkg::*;
#(
    parameter int NUM_SGI = 16,
    parameter int NUM_PE = 8
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [127:0] sw_set,
    input wire logic raise_valid,
    input wire logic [3:0] raise_id,
    input wire logic [2:0] raise_src,
    input wire logic retire_valid,
    input wire logic [3:0] retire_id,
    input wire logic [2:0] retire_src,
    output logic [127:0] pend
);
    pend_state_t st_reg; // registered pending bits
    pend_state_t st_next; // next value
    logic [127:0] impl; // bit exists in this build
    logic [127:0] hw_set; // raise decoded per bit
    logic [127:0] hw_clr; // retire decoded per bit

    // bit index is id*8+src, so id is the field and src the bit
    genvar b;
    generate
        for (b = 0; b < 128; b++) begin : g_bit
            assign impl[b] = ((b / 8) < NUM_SGI) && ((b % 8) < NUM_PE);
            assign hw_set[b] = raise_valid && ({raise_id, raise_src} == 7'(b));
            assign hw_clr[b] = retire_valid && ({retire_id, retire_src} == 7'(b));
        end
    endgenerate

    // set wins over a retire in the same cycle; missing bits stay zero
    always_comb begin
        st_next = st_reg;
        st_next.pend = ((st_reg.pend & ~hw_clr) | sw_set | hw_set) & impl;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '{pend: {4{`SGI_PEND_RESET}}};
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign pend = st_reg.pend;
endmodule

/* hw/distributor_sgi_status_type_regs.sv */
`timescale 1ns/1ps
`include "dist_regs.svh"

// Contract
// - four 8-bit fields, field x is 4n+x
// - read one means pending or active-pending
// - write one sets pending, zero no effect
// - pending fields reset to zero
// - register m/4, field m%4, bit C
// - pending register n at base plus 4n
// - absent error register reads zero, ignores writes
// - two security states bank error register
// - bit 2 flags read of write-only
// - bit 1 flags write to reserved
// - bit 0 flags read of reserved
// - writing one clears a flag
// - bit 25 reads zero when one-of-N exists
// - bit 24 reports nonzero affinity level 3
// - bits 23:19 identifier bits minus one
// - bit 18 direct injection, zero here
// - bit 17 reports locality interrupts
// - bit 16 message registers, else reserved
// - bit 10 two states, zero if disabled
// - bits 7:5 target elements minus one
// - bits 4:0 give shared range N
// - identifiers 1020-1023 never used
// - unimplemented pending bits read zero
// - group 0 bits hidden from non-secure

module distributor_sgi_status_type_regs
    import dist_pkg::*;
#(
    parameter int NUM_PE = 8, // targetable elements, 1..8
    parameter int NUM_SGI = 16, // implemented soft interrupts
    parameter bit TWO_SEC = 1'b1, // two security states built
    parameter bit ERR_STATUS_EN = 1'b1, // error register built
    parameter bit ONE_OF_N = 1'b1, // one-of-N distribution built
    parameter bit AFF3_EN = 1'b0, // nonzero affinity level 3
    parameter int ID_BITS = 10, // identifier width
    parameter bit DVI_EN = 1'b0, // must stay zero in version 3
    parameter bit LPI_EN = 1'b0, // locality interrupts built
    parameter bit MSG_EN = 1'b1, // message set/clear registers
    parameter logic [4:0] SPI_RANGE = 5'h1F // shared range field
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic acc_secure,
    input wire logic [11:0] acc_addr,
    input wire logic [3:0] acc_be,
    input wire logic [31:0] acc_wdata,
    input wire logic acc_claimed,
    input wire logic security_disable,
    input wire logic affinity_route_en,
    input wire logic [15:0] sgi_group1,
    input wire logic raise_valid,
    input wire logic [3:0] raise_id,
    input wire logic [2:0] raise_src,
    input wire logic retire_valid,
    input wire logic [3:0] retire_id,
    input wire logic [2:0] retire_src,
    output logic [31:0] rd_data_reg,
    output logic rd_done_reg,
    output logic [127:0] pending_vec,
    output logic [9:0] spi_limit_reg
);
    // largest shared identifier the range field allows
    localparam logic [10:0] SPI_MAX =
        11'(({6'h00, SPI_RANGE} + 11'h001) * `SPI_PER_STEP - 11'h001);

    // special identifiers are cut from the usable range
    localparam logic [9:0] SPI_LIMIT =
        (SPI_MAX >= `SPI_FIRST_SPECIAL) ? `SPI_LAST_USABLE : SPI_MAX[9:0];

    bank_state_t st_reg; // port state
    bank_state_t st_next; // next port state

    logic [11:0] word_addr; // word-aligned access address
    logic is_caps; // capability word
    logic is_err; // error status word
    logic is_pend; // one of four pending words
    logic is_msg; // message set/clear words
    logic is_wo; // write-only word
    logic mine; // decoded by this block
    logic reserved; // nobody owns the address
    logic sec_two; // two states in force
    logic copy_sel; // error copy for this access
    logic [6:0] pend_base; // first bit of addressed word
    logic [127:0] vis; // bits visible to this access
    logic [31:0] pend_word; // pending word as read
    logic [31:0] wr_word; // pending write after lanes
    logic [127:0] sw_set; // software set request
    logic [31:0] caps_word; // capability value
    logic [2:0] err_set [2]; // flag events per copy
    logic [2:0] err_clr [2]; // flag clears per copy
    logic [2:0] err_val [2]; // flag value per copy
    logic [31:0] rd_word; // read mux result

    // two states count only while security is not disabled
    assign sec_two = TWO_SEC && !security_disable;

    // secure traffic uses copy 1 while two states are in force, the rest copy 0
    assign copy_sel = sec_two && acc_secure;

    // byte lanes are given by acc_be, so low bits drop out
    assign word_addr = {acc_addr[11:2], 2'b00};

    // address decode
    always_comb begin
        is_caps = (word_addr == `CAPS_OFFSET);
        is_err = (word_addr == `ERR_STAT_OFFSET);
        is_pend = ((word_addr & `SGI_PEND_SPAN_MASK) == `SGI_PEND_BASE);
        is_msg = (word_addr == `SET_SHARED_NS_OFFSET)
              || (word_addr == `CLR_SHARED_NS_OFFSET)
              || (word_addr == `SET_SHARED_S_OFFSET)
              || (word_addr == `CLR_SHARED_S_OFFSET);
        // without message support those words become reserved
        is_wo = (word_addr == `SOFT_GEN_OFFSET) || (MSG_EN && is_msg);
        // the error word is ours even when not built: read zero
        mine = is_caps || is_err || is_pend || is_wo;
        // other distributor logic claims its own words
        reserved = !mine && !acc_claimed;
    end

    // word n covers bits 32n..32n+31, field x is soft id 4n+x
    assign pend_base = {acc_addr[3:2], 5'b00000};

    // group 0 bits hide from non-secure traffic while two states are in force
    genvar b;
    generate
        for (b = 0; b < 128; b++) begin : g_vis
            assign vis[b] = !(sec_two && !acc_secure && !sgi_group1[b / 8]);
        end
    endgenerate

    // reads mask hidden bits; missing bits are zero in the bank
    always_comb begin
        pend_word = pending_vec[pend_base +: 32] & vis[pend_base +: 32];
        if (affinity_route_en) begin
            // the word is reserved-zero under affinity routing
            pend_word = 32'h0000_0000;
        end
    end

    // software set: only enabled lanes, only visible bits
    always_comb begin
        wr_word = 32'h0000_0000;
        sw_set = '0;
        for (int k = 0; k < 4; k++) begin
            if (acc_be[k]) begin
                wr_word[k * `FIELD_BITS +: `FIELD_BITS] =
                    acc_wdata[k * `FIELD_BITS +: `FIELD_BITS];
            end
        end
        if (acc_valid && acc_write && is_pend && !affinity_route_en) begin
            // zero bits add nothing, so an OR is enough
            sw_set[pend_base +: 32] = wr_word & vis[pend_base +: 32];
        end
    end

    // the pending store
    sgi_pend_bank #(
        .NUM_SGI(NUM_SGI),
        .NUM_PE(NUM_PE)
    ) i_sgi_pend_bank (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ce(ce),
        .sw_set(sw_set),
        .raise_valid(raise_valid),
        .raise_id(raise_id),
        .raise_src(raise_src),
        .retire_valid(retire_valid),
        .retire_id(retire_id),
        .retire_src(retire_src),
        .pend(pending_vec)
    );

    // capability word: all other bits reserved zero
    always_comb begin
        caps_word = 32'h0000_0000;
        caps_word[`CAP_ONE_OF_N_BIT] = !ONE_OF_N;
        caps_word[`CAP_AFF3_BIT] = AFF3_EN;
        caps_word[`CAP_IDW_MSB:`CAP_IDW_LSB] = 5'(ID_BITS - 1);
        // direct injection is a later-version feature
        caps_word[`CAP_DVI_BIT] = 1'b0 & DVI_EN;
        caps_word[`CAP_LPI_BIT] = LPI_EN;
        caps_word[`CAP_MSG_BIT] = MSG_EN;
        caps_word[`CAP_SEC_BIT] = sec_two;
        caps_word[`CAP_TGT_MSB:`CAP_TGT_LSB] = 3'(NUM_PE - 1);
        caps_word[`CAP_SPI_MSB:`CAP_SPI_LSB] = SPI_RANGE;
    end

    // error events and clears, steered to one copy
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            err_set[c] = 3'h0;
            err_clr[c] = 3'h0;
            if (acc_valid && ERR_STATUS_EN && (copy_sel == c[0])) begin
                // a read of a write-only word
                err_set[c][`ERR_WO_READ_BIT] = !acc_write && is_wo;
                // a write to a reserved word
                err_set[c][`ERR_RSV_WRITE_BIT] = acc_write && reserved;
                // a read of a reserved word
                err_set[c][`ERR_RSV_READ_BIT] = !acc_write && reserved;
                if (acc_write && is_err && acc_be[0]) begin
                    err_clr[c] = acc_wdata[2:0];
                end
            end
        end
    end

    // copy 1 only ever moves when two states are in force
    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_err
            err_flags i_err_flags (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .ce(ce),
                .set_flags(err_set[c]),
                .clr_flags(err_clr[c]),
                .flags(err_val[c])
            );
        end
    endgenerate

    // read mux; unknown words and writes read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (is_caps) begin
            rd_word = caps_word;
        end else if (is_err) begin
            // not built: zero and writes go nowhere
            rd_word = ERR_STATUS_EN ? {29'h0, err_val[copy_sel]} : 32'h0;
        end else if (is_pend) begin
            rd_word = pend_word;
        end
    end

    // answer every access made while ce is high one cycle later
    always_comb begin
        st_next = st_reg;
        st_next.done = acc_valid;
        st_next.spi_limit = SPI_LIMIT;
        if (acc_valid) begin
            // read data stands until the next access
            st_next.rdata = acc_write ? 32'h0000_0000 : rd_word;
        end
    end

    // whole port state, frozen while ce is low
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state flops
    assign rd_data_reg = st_reg.rdata;
    assign rd_done_reg = st_reg.done;
    assign spi_limit_reg = st_reg.spi_limit;
endmodule

/* test/distributor_sgi_status_type_regs_asserts.sv */
`timescale 1ns/1ps
// watches the register port and the pending vector
module distributor_sgi_status_type_regs_asserts #(
    parameter logic [4:0] SPI_RANGE = 5'h1F
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic acc_secure,
    input wire logic [11:0] acc_addr,
    input wire logic acc_claimed,
    input wire logic security_disable,
    input wire logic raise_valid,
    input wire logic [3:0] raise_id,
    input wire logic [2:0] raise_src,
    input wire logic retire_valid,
    input wire logic [31:0] rd_data_reg,
    input wire logic rd_done_reg,
    input wire logic [127:0] pending_vec,
    input wire logic [9:0] spi_limit_reg
);
    // largest usable shared id, capped below the special identifiers
    localparam int RAW = 32 * (SPI_RANGE + 1) - 1;
    localparam int LIM = (RAW > 1019) ? 1019 : RAW;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // unclaimed read in an unmapped page
    sequence s_rsv_rd;
        ce && acc_valid && !acc_write && !acc_claimed && acc_addr[11:8] == 4'h1;
    endsequence
    // read of the error status word from the same security side as the cycle before
    sequence s_err_rd;
        ce && acc_valid && !acc_write && acc_addr == 12'h010 && acc_secure == $past(acc_secure);
    endsequence
    chk_done_follows: assert property ((ce && acc_valid) |=> rd_done_reg)
        else $error("access not answered one cycle later");
    chk_done_cause: assert property (rd_done_reg |-> $past(ce && acc_valid))
        else $error("answer without an access");
    chk_caps_value: assert property ((ce && acc_valid && !acc_write && acc_addr[11:2] == 10'h001)
        |=> rd_data_reg == ($past(security_disable) ? 32'h004900FF : 32'h004904FF))
        else $error("capability word wrong");
    chk_pend_hold: assert property (!retire_valid |=> (~pending_vec & $past(pending_vec)) == 0)
        else $error("pending bit lost without retire");
    chk_freeze_state: assert property (!ce |=> $stable(pending_vec) && $stable(rd_data_reg))
        else $error("state moved while disabled");
    chk_raise_sets: assert property ((ce && raise_valid)
        |=> pending_vec[{$past(raise_id), $past(raise_src)}])
        else $error("raise did not set pending");
    chk_spi_limit: assert property ($past(nrst) |-> spi_limit_reg == LIM[9:0])
        else $error("shared id limit wrong");
    chk_unmapped_rdz: assert property (s_rsv_rd |=> rd_data_reg == 32'h0)
        else $error("unmapped read not zero");
    chk_rsv_rd_flag: assert property (s_rsv_rd ##2 s_err_rd |=> rd_data_reg[0])
        else $error("reserved read not flagged");
    chk_err_upper_zero: assert property ((ce && acc_valid && !acc_write && acc_addr == 12'h010)
        |=> rd_data_reg[31:3] == 29'h0)
        else $error("error word upper bits not zero");
endmodule
bind distributor_sgi_status_type_regs distributor_sgi_status_type_regs_asserts
    #(.SPI_RANGE(SPI_RANGE)) i_chk (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
    .acc_valid(acc_valid), .acc_write(acc_write), .acc_secure(acc_secure),
    .acc_addr(acc_addr), .acc_claimed(acc_claimed), .security_disable(security_disable),
    .raise_valid(raise_valid), .raise_id(raise_id), .raise_src(raise_src),
    .retire_valid(retire_valid), .rd_data_reg(rd_data_reg), .rd_done_reg(rd_done_reg),
    .pending_vec(pending_vec), .spi_limit_reg(spi_limit_reg));

/* test/distributor_sgi_status_type_regs_tb_top.sv */
`timescale 1ns/1ps
// compare, count and report at once
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); end end
module distributor_sgi_status_type_regs_tb_top;
    logic sys_clk = 1'b0, nrst = 1'b0, ce = 1'b1, acc_valid = 1'b0, acc_write = 1'b0;
    logic acc_secure = 1'b1, acc_claimed = 1'b0, security_disable = 1'b0;
    logic [11:0] acc_addr = 12'h0;
    logic [3:0] acc_be = 4'h0, raise_id = 4'h0, retire_id = 4'h0;
    logic [31:0] acc_wdata = 32'h0, rd_data_reg, q;
    logic [15:0] sgi_group1 = 16'hFFFF;
    logic raise_valid = 1'b0, retire_valid = 1'b0, rd_done_reg;
    logic [2:0] raise_src = 3'h0, retire_src = 3'h0;
    logic [127:0] pending_vec, exp_pend = 128'h0;
    logic [9:0] spi_limit_reg;
    int bad_count = 0, checks_done = 0;
    // 40 MHz
    always #12.5 sys_clk = ~sys_clk;
    // affinity routing stays off: the pending words are only live then
    distributor_sgi_status_type_regs i_distributor_sgi_status_type_regs (.sys_clk(sys_clk),
        .nrst(nrst), .ce(ce), .acc_valid(acc_valid), .acc_write(acc_write),
        .acc_secure(acc_secure), .acc_addr(acc_addr), .acc_be(acc_be), .acc_wdata(acc_wdata),
        .acc_claimed(acc_claimed), .security_disable(security_disable),
        .affinity_route_en(1'b0), .sgi_group1(sgi_group1), .raise_valid(raise_valid),
        .raise_id(raise_id), .raise_src(raise_src), .retire_valid(retire_valid),
        .retire_id(retire_id), .retire_src(retire_src), .rd_data_reg(rd_data_reg),
        .rd_done_reg(rd_done_reg), .pending_vec(pending_vec), .spi_limit_reg(spi_limit_reg));
    // one access; a spare cycle follows so strobes never toggle twice at one edge
    task automatic acc(input logic w, input logic s, input logic [11:0] a,
        input logic [3:0] be, input logic [31:0] d);
        @(negedge sys_clk);
        acc_valid = 1'b1;
        acc_write = w;
        acc_secure = s;
        acc_addr = a;
        acc_be = be;
        acc_wdata = d;
        @(negedge sys_clk);
        acc_valid = 1'b0;
        q = rd_data_reg;
        `CHK(rd_done_reg, 1'b1)
    endtask
    // capability word for the default build
    function automatic logic [31:0] caps(input logic sd);
        return {6'h0, 2'b00, 5'd9, 3'b001, 5'h0, !sd, 2'h0, 3'd7, 5'h1F};
    endfunction
    task automatic t_caps();
        for (int i = 0; i < 2; i++) begin
            security_disable = i[0];
            acc(1'b0, 1'b1, 12'h004, 4'h0, 32'h0);
            `CHK(q, caps(i[0]))
        end
        security_disable = 1'b0;
        acc(1'b1, 1'b1, 12'h004, 4'hF, 32'hFFFF_FFFF);
        acc(1'b0, 1'b0, 12'h004, 4'h0, 32'h0);
        `CHK(q, caps(1'b0))
        $display("caps test done");
    endtask
    // lanes 1 and 3 are masked off although their data is nonzero
    task automatic t_pend();
        logic [31:0] d;
        for (int n = 0; n < 4; n++) begin
            d = 32'h0102_0408 << n;
            acc(1'b1, 1'b1, 12'hF20 + 12'(4 * n), 4'b0101, d);
            exp_pend[n*32 +: 32] |= d & 32'h00FF_00FF;
        end
        `CHK(pending_vec, exp_pend)
        acc(1'b1, 1'b1, 12'hF20, 4'hF, 32'h0);
        `CHK(pending_vec, exp_pend)
        for (int n = 0; n < 4; n++) begin
            acc(1'b0, 1'b1, 12'hF20 + 12'(4 * n), 4'h0, 32'h0);
            `CHK(q, exp_pend[n*32 +: 32])
        end
        // raise id 15 from element 7 while retiring id 0 element 3
        @(negedge sys_clk);
        {raise_valid, raise_id, raise_src} = {1'b1, 4'hF, 3'h7};
        {retire_valid, retire_id, retire_src} = {1'b1, 4'h0, 3'h3};
        @(negedge sys_clk);
        raise_valid = 1'b0;
        retire_valid = 1'b0;
        exp_pend[127] = 1'b1;
        exp_pend[3] = 1'b0;
        acc(1'b0, 1'b1, 12'hF2C, 4'h0, 32'h0);
        `CHK(q, exp_pend[127:96])
        `CHK(pending_vec, exp_pend)
        $display("pending test done");
    endtask
    // group 0 ids are hidden from the non-secure side
    task automatic t_group();
        logic [31:0] m;
        sgi_group1 = 16'h0F0F;
        acc(1'b1, 1'b0, 12'hF24, 4'hF, 32'hFFFF_FFFF);
        `CHK(pending_vec, exp_pend)
        for (int n = 0; n < 4; n++) begin
            for (int x = 0; x < 4; x++) m[x*8 +: 8] = {8{sgi_group1[4*n+x]}};
            acc(1'b0, 1'b0, 12'hF20 + 12'(4 * n), 4'h0, 32'h0);
            `CHK(q, exp_pend[n*32 +: 32] & m)
        end
        sgi_group1 = 16'hFFFF;
        $display("group test done");
    endtask
    task automatic t_err();
        acc(1'b0, 1'b1, 12'hF00, 4'h0, 32'h0);
        acc(1'b1, 1'b1, 12'h100, 4'hF, 32'h1);
        acc(1'b0, 1'b1, 12'h104, 4'h0, 32'h0);
        acc(1'b0, 1'b1, 12'h010, 4'h0, 32'h0);
        `CHK(q[2:0], 3'b111)
        acc_claimed = 1'b1;
        acc(1'b0, 1'b0, 12'h104, 4'h0, 32'h0);
        acc_claimed = 1'b0;
        acc(1'b0, 1'b0, 12'h010, 4'h0, 32'h0);
        `CHK(q, 32'h0)
        acc(1'b1, 1'b1, 12'h010, 4'h1, 32'h5);
        acc(1'b0, 1'b1, 12'h010, 4'h0, 32'h0);
        `CHK(q, 32'h2)
        $display("error test done");
    endtask
    // a disabled clock enable drops the access
    task automatic t_ce();
        // let the last answer pulse drop before freezing, or it would stay frozen high
        @(negedge sys_clk);
        ce = 1'b0;
        acc_write = 1'b1;
        acc_addr = 12'hF28;
        acc_be = 4'hF;
        acc_wdata = 32'hFFFF_FFFF;
        acc_valid = 1'b1;
        @(negedge sys_clk);
        acc_valid = 1'b0;
        @(negedge sys_clk);
        ce = 1'b1;
        `CHK(rd_done_reg, 1'b0)
        `CHK(pending_vec, exp_pend)
        $display("enable test done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (12) @(negedge sys_clk);
        nrst = 1'b1;
        @(negedge sys_clk);
        `CHK(pending_vec, 128'h0)
        `CHK(spi_limit_reg, 10'h3FB)
        t_caps();
        t_pend();
        t_group();
        t_err();
        t_ce();
        tally_and_finish();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        tally_and_finish();
    end
endmodule
